/* File: core/sapr_core.sv */
// Conversion control and parallel read port of a 16-bit SAR converter.
// Assumes clk_sys_in at 200 MHz; conversion clock, trigger, selects arrive as pins.
`timescale 1ns/1ps
`default_nettype none
`include "sapr_params.svh"
module sapr_core #(
  parameter int RESULT_W   = `SAPR_RESULT_W,
  parameter int FIFO_DEPTH = `SAPR_FIFO_DEPTH
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  input  wire logic                conv_clk_in,
  input  wire logic                sample_hold_trigger_n_in,
  input  wire logic                chip_sel_n_in,
  input  wire logic                read_n_in,
  input  wire logic                byte_sel_in,
  input  wire logic [RESULT_W-1:0] sar_code_in,
  output logic                     busy_out,
  output logic                     hold_out,
  output logic [RESULT_W-1:0]      result_bus_out,
  output logic [RESULT_W-1:0]      result_bus_oe_out
);
  if (RESULT_W != 2 * `SAPR_BYTE_W) begin : g_width_check
    $error("sapr_core: RESULT_W must be 16");
  end

  localparam int HB = `SAPR_BYTE_W;

  // Two-stage synchronisers for every pin except clock and reset; stage one feeds stage two only
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [RESULT_W-1:0] code_s1_reg;
  logic [RESULT_W-1:0] code_s2_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= 5'h1E;
      sync2_reg <= 5'h1E;
    end else begin
      sync1_reg <= {sample_hold_trigger_n_in, chip_sel_n_in, read_n_in, byte_sel_in, conv_clk_in};
      sync2_reg <= sync1_reg;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      code_s1_reg <= `SAPR_RESULT_RST;
      code_s2_reg <= `SAPR_RESULT_RST;
    end else begin
      code_s1_reg <= sar_code_in;
      code_s2_reg <= code_s1_reg;
    end
  end

  wire trig_n_s = sync2_reg[4];
  wire cs_n_s   = sync2_reg[3];
  wire rd_n_s   = sync2_reg[2];
  wire bsel_s   = sync2_reg[1];
  wire cclk_s   = sync2_reg[0];

  logic trig_n_d_reg;
  logic cclk_d_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_n_d_reg <= 1'b1;
      cclk_d_reg   <= 1'b0;
    end else begin
      trig_n_d_reg <= trig_n_s;
      cclk_d_reg   <= cclk_s;
    end
  end

  // Only an edge starts a conversion, so a trigger held low is harmless
  wire trig_fall = trig_n_d_reg && !trig_n_s;
  wire cclk_rise = !cclk_d_reg && cclk_s;
  wire start_ok  = trig_fall && !cs_n_s;

  sapr_pkg::sapr_state_t state_reg;
  sapr_pkg::sapr_state_t state_next;
  logic [4:0] edge_cnt_reg;
  logic [4:0] edge_cnt_next;

  wire idle_now   = (state_reg == sapr_pkg::SAPR_IDLE);
  wire last_edge  = (state_reg == sapr_pkg::SAPR_CONV) && cclk_rise &&
                    (edge_cnt_reg == 5'(`SAPR_LATCH_EDGE - 1));
  wire busy_next  = (idle_now && start_ok) ||
                    (!idle_now && !last_edge);

  always_comb begin
    state_next    = state_reg;
    edge_cnt_next = edge_cnt_reg;
    case (state_reg)
      sapr_pkg::SAPR_IDLE: begin
        if (start_ok) begin
          state_next    = sapr_pkg::SAPR_WAIT;
          edge_cnt_next = 5'h00;
        end
      end
      sapr_pkg::SAPR_WAIT: begin
        if (cclk_rise) begin
          state_next    = sapr_pkg::SAPR_CONV;
          edge_cnt_next = 5'h01;
        end
      end
      sapr_pkg::SAPR_CONV: begin
        // Extra trigger edges are not looked at here
        if (cclk_rise) begin
          if (last_edge) begin
            state_next    = sapr_pkg::SAPR_IDLE;
            edge_cnt_next = 5'h00;
          end else begin
            edge_cnt_next = edge_cnt_reg + 5'h01;
          end
        end
      end
      default: begin
        state_next    = sapr_pkg::SAPR_IDLE;
        edge_cnt_next = 5'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg    <= sapr_pkg::SAPR_IDLE;
      edge_cnt_reg <= 5'h00;
      busy_out     <= 1'b0;
      hold_out     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      edge_cnt_reg <= edge_cnt_next;
      busy_out     <= busy_next;
      hold_out     <= busy_next;
    end
  end

  // Finished codes queue in the FIFO; the output register takes the newest
  sapr_fifo_if #(.W(RESULT_W)) conv_if ();
  assign conv_if.valid = last_edge;
  assign conv_if.data  = code_s2_reg;

  logic                fifo_valid;
  logic [RESULT_W-1:0] fifo_data;
  sapr_fifo #(
    .W     (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .wr           (conv_if),
    .rd_ready_in  (1'b1),
    .rd_valid_out (fifo_valid),
    .rd_data_out  (fifo_data)
  );

  logic [RESULT_W-1:0] out_word_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_word_reg <= `SAPR_RESULT_RST;
    end else if (fifo_valid) begin
      out_word_reg <= fifo_data;
    end
  end

  // Read window: count the cycles both strobes have been low
  logic [3:0] rd_cnt_reg;
  wire        rd_act = !cs_n_s && !rd_n_s;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_cnt_reg <= 4'h0;
    end else if (!rd_act) begin
      rd_cnt_reg <= 4'h0;
    end else if (rd_cnt_reg != 4'hF) begin
      rd_cnt_reg <= rd_cnt_reg + 4'h1;
    end
  end

  // Byte mode shifts the upper half down onto the low lines
  wire [RESULT_W-1:0] bus_word = bsel_s ? {{HB{1'b0}}, out_word_reg[RESULT_W-1:HB]}
                                        : out_word_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_bus_out    <= '0;
      result_bus_oe_out <= '0;
    end else begin
      result_bus_out    <= bus_word;
      result_bus_oe_out <= {RESULT_W{rd_act}};
    end
  end

  property p_busy_rise;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (idle_now && start_ok) |=> busy_out;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  property p_busy_fall;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      last_edge |=> !busy_out && (out_word_reg == $past(code_s2_reg, 1) || fifo_valid);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy not dropped");

  property p_no_start_cs;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (idle_now && cs_n_s) |=> !busy_out;
  endproperty
  a_no_start_cs: assert property (p_no_start_cs) else $error("start without select");

  property p_ignore_retrig;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (state_reg == sapr_pkg::SAPR_CONV && trig_fall && !last_edge) |=>
        (state_reg == sapr_pkg::SAPR_CONV);
  endproperty
  a_ignore_retrig: assert property (p_ignore_retrig) else $error("retrigger taken");

  property p_held_low;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (idle_now && !trig_n_s && !trig_n_d_reg) |=> !busy_out;
  endproperty
  a_held_low: assert property (p_held_low) else $error("held trigger restarted");

  property p_oe;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      1'b1 |=> (result_bus_oe_out == {RESULT_W{$past(rd_act)}});
  endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");

  property p_byte;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (bsel_s && !fifo_valid) |=> (result_bus_out[HB-1:0] == out_word_reg[RESULT_W-1:HB]);
  endproperty
  a_byte: assert property (p_byte) else $error("byte lane wrong");

  property p_keep;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !fifo_valid |=> $stable(out_word_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("result changed");

  property p_conv_len;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (state_reg == sapr_pkg::SAPR_CONV) |-> (edge_cnt_reg <= 5'(`SAPR_CONV_EDGES));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too long");

  property p_wait_conv;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (state_reg == sapr_pkg::SAPR_WAIT && cclk_rise) |=>
        (state_reg == sapr_pkg::SAPR_CONV && edge_cnt_reg == 5'h01);
  endproperty
  a_wait_conv: assert property (p_wait_conv) else $error("conversion start missed");

  property p_busy_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (state_reg == sapr_pkg::SAPR_CONV && !last_edge) |=> busy_out;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_sample_back;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      last_edge |=> !hold_out;
  endproperty
  a_sample_back: assert property (p_sample_back) else $error("input still held");

  property p_full_word;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (!bsel_s && !fifo_valid) |=> (result_bus_out == out_word_reg);
  endproperty
  a_full_word: assert property (p_full_word) else $error("word lanes wrong");

  property p_upper_zero;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      bsel_s |=> (result_bus_out[RESULT_W-1:HB] == {HB{1'b0}});
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lanes not idle");

  // The bus enable must already stand once the strobes have been low for the valid time
  property p_rd_valid;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (rd_act && rd_cnt_reg == 4'(`SAPR_RD_VALID_CYC)) |->
        (result_bus_oe_out == {RESULT_W{1'b1}});
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read data late");

  // A full queue would drop a finished code silently
  property p_fifo_room;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      conv_if.valid |-> conv_if.ready;
  endproperty
  a_fifo_room: assert property (p_fifo_room) else $error("result queue full");
endmodule
`default_nettype wire

/* File: core/sapr_params.svh */
// Constants for the converter control and parallel read port.
// Assumes inclusion by bare name from core/ sources.
`ifndef SAPR_PARAMS_SVH
`define SAPR_PARAMS_SVH

`define SAPR_CLK_PERIOD_PS     5000
`define SAPR_BUSY_MAX_PS       25000
`define SAPR_HOLD_MAX_PS       10000
`define SAPR_RD_VALID_PS       40000
`define SAPR_BUSY_CYC          ((`SAPR_BUSY_MAX_PS / `SAPR_CLK_PERIOD_PS) > 0 ? \
                                (`SAPR_BUSY_MAX_PS / `SAPR_CLK_PERIOD_PS) : 1)
`define SAPR_RD_VALID_CYC      ((`SAPR_RD_VALID_PS + `SAPR_CLK_PERIOD_PS - 1) / \
                                `SAPR_CLK_PERIOD_PS)
`define SAPR_CONV_EDGES        16
`define SAPR_LATCH_EDGE        17
`define SAPR_RESULT_W          16
`define SAPR_BYTE_W            8
`define SAPR_RESULT_RST        16'h0000
`define SAPR_FIFO_DEPTH        4

`endif

/* File: core/sapr_pkg.sv */
// Types for the converter control and parallel read port.
// Assumes sapr_params.svh is available.
package sapr_pkg;
  typedef enum logic [1:0] {
    SAPR_IDLE = 2'b00,
    SAPR_WAIT = 2'b01,
    SAPR_CONV = 2'b10
  } sapr_state_t;
endpackage

/* File: core/sapr_fifo_if.sv */
// Valid/ready carrier between the conversion core and the result FIFO.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface sapr_fifo_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: core/sapr_fifo.sv */
// Result FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sapr_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic   clk_sys_in,
  input  wire logic   rstn_in,
  sapr_fifo_if.snk    wr,
  input  wire logic   rd_ready_in,
  output logic        rd_valid_out,
  output logic [W-1:0] rd_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("sapr_fifo: DEPTH must be power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  wire          full  = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  wire          empty = (wptr_reg == rptr_reg);
  wire          push  = wr.valid && !full;
  wire          pop   = rd_ready_in && !empty;
  assign wr.ready     = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rptr_reg[AW-1:0]];
  always_ff @(posedge clk_sys_in) begin
    if (push) mem[wptr_reg[AW-1:0]] <= wr.data;
  end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop)  rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/sapr_host_model.sv */
// Host model: free-running conversion clock, trigger pulses, parallel reads.
// Assumes the bench calls its tasks; pins change on system clock falling edges.
`timescale 1ns/1ps
`default_nettype none
module sapr_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        busy_in,
  input  wire logic [15:0] bus_in,
  input  wire logic [15:0] oe_in,
  output logic             conv_clk_out,
  output logic             trig_n_out,
  output logic             cs_n_out,
  output logic             rd_n_out,
  output logic             byte_sel_out
);
  int unsigned ph = 0;
  initial conv_clk_out = 1'b0;
  initial trig_n_out = 1'b1;
  initial cs_n_out = 1'b1;
  initial rd_n_out = 1'b1;
  initial byte_sel_out = 1'b0;
  // 10 MHz, free running
  always @(negedge clk_sys_in) begin
    ph <= (ph == 9) ? 0 : ph + 1;
    if (ph == 9) conv_clk_out <= ~conv_clk_out;
  end
  // Falls one system clock after the conversion clock falls, so the next rise is well over 10 ns away
  task automatic pulse(input logic cs_n, input int low_cyc, output int lat);
    lat = -1;
    repeat (25) @(negedge clk_sys_in);
    @(negedge conv_clk_out);
    @(negedge clk_sys_in);
    cs_n_out <= cs_n;
    trig_n_out <= 1'b0;
    for (int i = 1; i <= low_cyc; i++) begin
      @(negedge clk_sys_in);
      if (busy_in === 1'b1 && lat < 0) lat = i;
    end
    trig_n_out <= 1'b1;
    repeat (6) @(negedge clk_sys_in);
  endtask
  // Samples after 40 ns low, then keeps strobe high over 20 ns
  task automatic rd(input logic bsel, input logic cs_n, output logic [15:0] d,
                    output logic [15:0] oe, output logic [15:0] oe2);
    @(negedge clk_sys_in);
    byte_sel_out <= bsel;
    cs_n_out <= cs_n;
    rd_n_out <= 1'b0;
    repeat (8) @(negedge clk_sys_in);
    d = bus_in;
    oe = oe_in;
    rd_n_out <= 1'b1;
    repeat (4) @(negedge clk_sys_in);
    oe2 = oe_in;
  endtask
endmodule
`default_nettype wire

/* File: tb/sapr_adc_parallel_readout_bench.sv */
// Self-checking bench for the converter control and parallel read port.
// Assumes the host model drives every pin except clock, reset and the result code.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module sapr_adc_parallel_readout_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] sar_code = 16'h0000;
  logic        conv_clk, trig_n, cs_n, rd_n, bsel, busy_out, hold_out;
  logic [15:0] bus, oe;
  int          fails = 0, comparisons = 0, rises = 0, busy_ups = 0;
  always #2.5 clk = ~clk;
  always @(posedge conv_clk) if (busy_out === 1'b1) rises++;
  always @(posedge busy_out) busy_ups++;
  sapr_core i_dut (.clk_sys_in(clk), .rstn_in(rstn), .conv_clk_in(conv_clk),
    .sample_hold_trigger_n_in(trig_n), .chip_sel_n_in(cs_n), .read_n_in(rd_n),
    .byte_sel_in(bsel), .sar_code_in(sar_code), .busy_out(busy_out),
    .hold_out(hold_out), .result_bus_out(bus), .result_bus_oe_out(oe));
  sapr_host_model i_host (.clk_sys_in(clk), .busy_in(busy_out), .bus_in(bus),
    .oe_in(oe), .conv_clk_out(conv_clk), .trig_n_out(trig_n), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .byte_sel_out(bsel));
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
    end
    `CHK(n < 600, 1'b1)
  endtask
  task automatic t_reset();
    logic [15:0] d, o, o2;
    `CHK(busy_out, 1'b0)
    `CHK(oe, 16'h0000)
    i_host.rd(1'b0, 1'b0, d, o, o2);
    `CHK(d, 16'h0000)
    `CHK(busy_out, 1'b0)
  endtask
  task automatic t_convert(input logic [15:0] code);
    int lat;
    logic [15:0] d, o, o2;
    sar_code = code;
    rises = 0;
    i_host.pulse(1'b0, 6, lat);
    `CHK(lat >= 1 && lat <= 5, 1'b1)
    `CHK(hold_out, 1'b1)
    wait_idle();
    `CHK(rises, 17)
    `CHK(hold_out, 1'b0)
    repeat (80) @(negedge clk);
    i_host.rd(1'b0, 1'b0, d, o, o2);
    `CHK(d, code)
    `CHK(o, 16'hFFFF)
    `CHK(o2, 16'h0000)
    i_host.rd(1'b1, 1'b0, d, o, o2);
    `CHK(d[7:0], code[15:8])
    `CHK(busy_out, 1'b0)
  endtask
  task automatic t_ignore();
    int lat, ups;
    sar_code = 16'h1234;
    rises = 0;
    i_host.pulse(1'b0, 6, lat);
    repeat (100) @(negedge clk);
    i_host.pulse(1'b0, 6, lat);
    wait_idle();
    `CHK(rises, 17)
    ups = busy_ups;
    repeat (100) @(negedge clk);
    `CHK(busy_ups, ups)
  endtask
  task automatic t_held();
    int lat, ups;
    sar_code = 16'h0F0F;
    ups = busy_ups;
    i_host.pulse(1'b0, 400, lat);
    repeat (100) @(negedge clk);
    `CHK(busy_ups, ups + 1)
    `CHK(busy_out, 1'b0)
  endtask
  task automatic t_cs_high();
    int lat, ups;
    logic [15:0] d, o, o2;
    sar_code = 16'hA5A5;
    ups = busy_ups;
    i_host.pulse(1'b1, 6, lat);
    `CHK(lat, -1)
    repeat (400) @(negedge clk);
    `CHK(busy_ups, ups)
    i_host.rd(1'b0, 1'b1, d, o, o2);
    `CHK(o, 16'h0000)
    i_host.rd(1'b0, 1'b0, d, o, o2);
    `CHK(d, 16'h0F0F)
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_convert(16'h7FFF);
    t_convert(16'h0000);
    t_convert(16'hFFFF);
    t_convert(16'h8000);
    t_ignore();
    t_held();
    t_cs_high();
    give_verdict();
  end
endmodule
`default_nettype wire
